// ==== src/itc_pkg.sv ====
// Shared constants, types and field layouts for the interval timer channel.
`default_nettype none
package itc_pkg;
	// ------------------------------------------------------------
	// Bus map
	// ------------------------------------------------------------
	localparam int unsigned PADDR_W = 8;
	localparam logic [1:0] IDX_CH0 = 2'h0;
	localparam logic [1:0] IDX_CH1 = 2'h1;
	localparam logic [1:0] IDX_CH2 = 2'h2;
	localparam logic [1:0] IDX_CTRL = 2'h3;
	localparam int unsigned IDX_LSB = 2;
	localparam int unsigned IDX_MSB = 3;
	localparam int unsigned HIGH_LSB = 4;
	localparam logic [1:0] ALIGN_OK = 2'h0;
	localparam logic [3:0] HIGH_OK = 4'h0;
	// ------------------------------------------------------------
	// Control word codes
	// ------------------------------------------------------------
	localparam logic [1:0] CH_OWN = 2'h0;
	localparam logic [1:0] FMT_LATCH = 2'h0;
	localparam logic [1:0] FMT_LOW = 2'h1;
	localparam logic [1:0] FMT_HIGH = 2'h2;
	localparam logic [1:0] FMT_BOTH = 2'h3;
	// ------------------------------------------------------------
	// Values
	// ------------------------------------------------------------
	localparam logic [15:0] COUNT_CLEAR = 16'h0000;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	localparam logic [15:0] COUNT_TWO = 16'h0002;
	localparam logic [15:0] EVEN_MASK = 16'hfffe;
	localparam logic [3:0] DIGIT_ZERO = 4'h0;
	localparam logic [3:0] DIGIT_NINE = 4'h9;
	localparam logic [3:0] DIGIT_ONE = 4'h1;
	localparam logic WAVE_RST = 1'b1;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [23:0] PAD_ZERO = 24'h000000;
	localparam logic [31:0] WORD_ZERO = 32'h00000000;

	typedef enum logic [2:0] {
		ITC_M0, ITC_M1, ITC_M2, ITC_M3, ITC_M4, ITC_M5
	} itc_mode_e;

	// Control word: channel_pick, transfer_format, waveform_select, bcd.
	typedef struct packed {
		logic [1:0] channel_pick_field;
		logic [1:0] transfer_format_field;
		logic [2:0] waveform_select_field;
		logic bcd;
	} itc_cw_s;

	// Synchronised pin events.
	typedef struct packed {
		logic gate;
		logic gate_rise;
		logic tick;
	} itc_pin_ev_s;

	// Status byte at the control index.
	typedef struct packed {
		logic wave;
		logic null_count;
		logic [1:0] fmt;
		logic [2:0] mode;
		logic bcd;
	} itc_status_s;
endpackage
`default_nettype wire

// ==== src/itc_pin_sync.sv ====
// Pin synchroniser and edge detector for the counter clock and gate pins.
`timescale 1ns/1ps
`default_nettype none
module itc_pin_sync (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pins
	input wire logic cnt_clk_pin,
	input wire logic gate_pin,
	// Events
	output itc_pkg::itc_pin_ev_s ev
);
	logic [1:0] stage1;
	logic [1:0] stage2;
	logic [1:0] stage3;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1 <= 2'h0;
			stage2 <= 2'h0;
			stage3 <= 2'h0;
		end else begin
			stage1 <= {gate_pin, cnt_clk_pin};
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Counter clock becomes a one-cycle enable on its rising edge.
	assign ev = '{gate: stage2[1], gate_rise: stage2[1] & ~stage3[1],
		tick: stage2[0] & ~stage3[0]};
endmodule
`default_nettype wire

// ==== src/itc_timer.sv ====
// Interval timer channel with APB register access.
//
// Function
// - Mode 0: wave low on setup, counts after full load, high at end.
// - Mode 0: low gate pauses decrementing, high gate resumes.
// - Mode 0 one-byte: new count halts, reloads on next counter clock.
// - Mode 0 two-byte: low byte halts, high byte starts new count.
// - Mode 1: wave high, gate rise triggers low pulse of count length.
// - Mode 1: gate low ignored; new count waits for next trigger.
// - Mode 2: starts next clock if gate high, else on gate rise.
// - Mode 2: one-clock low pulse every n counter clocks.
// - Mode 2: new count applies after current period's pulse.
// - Modes 2 and 3: gate low stops and forces wave high; rise restarts.
// - Mode 3: square wave period n, odd n high one clock longer.
// - Mode 3: new count applies right after next wave transition.
// - Mode 4: wave high, counts like mode 0, single one-clock low strobe.
// - Mode 4: gate low stops; gate rise restarts from programmed count.
// - Mode 5: gate rise starts or retriggers, mode 4 style strobe.
// - Count zero means 10000H; modes 0,1,4,5 accept one.
// - Modes 2,3 minimum two; mode 3 count one gives 10001H.
// - Counting element only decrements, by two in mode 3.
// - Latch command freezes count for reading while counting continues.
// - Transfer format: latch, low only, high only, low then high.
// - Waveform field picks modes 0 to 5; top bit ignored for 2,3.
// - Control word write other than latch command clears counting element to 0000H.
// - Index 0 selects the counter, index 3 the control word; 1,2 read zero.
`timescale 1ns/1ps
`default_nettype none
module itc_timer (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [itc_pkg::PADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Timer pins
	input wire logic cnt_clk_pin,
	input wire logic gate_pin,
	output logic wave_out
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic itc_pkg::itc_mode_e mode_of(input logic [2:0] m);
		if (m[1]) begin
			mode_of = m[0] ? itc_pkg::ITC_M3 : itc_pkg::ITC_M2;
		end else if (m[2]) begin
			mode_of = m[0] ? itc_pkg::ITC_M5 : itc_pkg::ITC_M4;
		end else begin
			mode_of = m[0] ? itc_pkg::ITC_M1 : itc_pkg::ITC_M0;
		end
	endfunction

	function automatic logic [15:0] dec1(input logic [15:0] v,
		input logic bcd);
		logic [15:0] r;
		logic brw;
		r = v;
		brw = 1'b1;
		if (!bcd) begin
			r = v - itc_pkg::COUNT_ONE;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (brw) begin
					if (r[i*4 +: 4] == itc_pkg::DIGIT_ZERO) begin
						r[i*4 +: 4] = itc_pkg::DIGIT_NINE;
					end else begin
						r[i*4 +: 4] = r[i*4 +: 4] - itc_pkg::DIGIT_ONE;
						brw = 1'b0;
					end
				end
			end
		end
		dec1 = r;
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	itc_pkg::itc_pin_ev_s ev;
	itc_pkg::itc_mode_e mode;
	logic [1:0] fmt;
	logic bcd;
	logic [15:0] cr;
	logic [7:0] cr_lo;
	logic [15:0] ce;
	logic [15:0] latch;
	logic latched;
	logic wr_msb;
	logic rd_msb;
	logic running;
	logic load_pending;
	logic halt;
	logic have_count;
	logic trig;
	logic stretch;
	logic [15:0] next_ce;
	logic next_out;
	logic next_run;
	logic next_pend;
	logic next_halt;
	logic next_have;
	logic next_trig;
	logic next_str;

	itc_pin_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.cnt_clk_pin(cnt_clk_pin),
		.gate_pin(gate_pin),
		.ev(ev)
	);

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire [1:0] idx = paddr[itc_pkg::IDX_MSB:itc_pkg::IDX_LSB];
	wire addr_ok = (paddr[1:0] == itc_pkg::ALIGN_OK) &&
		(paddr[itc_pkg::PADDR_W-1:itc_pkg::HIGH_LSB] == itc_pkg::HIGH_OK);
	wire acc = psel & penable & pready;
	wire wr_go = acc & pwrite & addr_ok;
	wire rd_go = acc & ~pwrite & addr_ok;
	wire [7:0] wd = pwdata[7:0];
	itc_pkg::itc_cw_s cw;
	assign cw = wd;
	wire cw_wr = wr_go && (idx == itc_pkg::IDX_CTRL) &&
		(cw.channel_pick_field == itc_pkg::CH_OWN);
	wire latch_cmd = cw_wr &&
		(cw.transfer_format_field == itc_pkg::FMT_LATCH);
	wire mode_wr = cw_wr && !latch_cmd;
	wire cnt_wr = wr_go && (idx == itc_pkg::IDX_CH0);
	wire lsb_part = cnt_wr && (fmt == itc_pkg::FMT_BOTH) && !wr_msb;
	wire cnt_done = cnt_wr && !lsb_part;
	wire rd_sel = rd_go && (idx == itc_pkg::IDX_CH0);
	wire itc_pkg::itc_mode_e new_mode = mode_of(cw.waveform_select_field);

	// ------------------------------------------------------------
	// Counting decode
	// ------------------------------------------------------------
	wire [15:0] dec = dec1(ce, bcd);
	wire [15:0] dec2 = dec1(dec, bcd);
	wire [15:0] cr_even = cr & itc_pkg::EVEN_MASK;
	wire m04 = (mode == itc_pkg::ITC_M0) || (mode == itc_pkg::ITC_M4);
	wire m23 = (mode == itc_pkg::ITC_M2) || (mode == itc_pkg::ITC_M3);
	wire at_one = (ce == itc_pkg::COUNT_ONE);
	wire at_two = (ce == itc_pkg::COUNT_TWO);

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	wire [15:0] rd_src = latched ? latch : ce;
	wire rd_hi = (fmt == itc_pkg::FMT_HIGH) ||
		((fmt == itc_pkg::FMT_BOTH) && rd_msb);
	wire [7:0] rd_byte = rd_hi ? rd_src[15:8] : rd_src[7:0];
	itc_pkg::itc_status_s status;
	assign status = '{wave: wave_out, null_count: load_pending, fmt: fmt,
		mode: mode, bcd: bcd};
	wire [31:0] rd_word = !addr_ok ? itc_pkg::WORD_ZERO :
		(idx == itc_pkg::IDX_CH0) ? {itc_pkg::PAD_ZERO, rd_byte} :
		(idx == itc_pkg::IDX_CTRL) ? {itc_pkg::PAD_ZERO, status} :
		itc_pkg::WORD_ZERO;

	// ------------------------------------------------------------
	// Counter next state
	// ------------------------------------------------------------
	always_comb begin
		next_ce = ce;
		next_out = wave_out;
		next_run = running;
		next_pend = load_pending;
		next_halt = halt;
		next_have = have_count;
		next_trig = trig | ev.gate_rise;
		next_str = stretch;
		if (ev.tick) begin
			next_trig = ev.gate_rise;
			case (mode)
			itc_pkg::ITC_M0, itc_pkg::ITC_M4: begin
				if (mode == itc_pkg::ITC_M4 && !wave_out) begin
					next_out = 1'b1;
				end
				if (load_pending) begin
					next_ce = cr;
					next_pend = 1'b0;
					next_halt = 1'b0;
					next_run = 1'b1;
				end else if (running && ev.gate && !halt) begin
					next_ce = dec;
					if (at_one) begin
						if (mode == itc_pkg::ITC_M0) begin
							next_out = 1'b1;
						end else begin
							next_out = 1'b0;
							next_run = 1'b0;
						end
					end
				end
			end
			itc_pkg::ITC_M1, itc_pkg::ITC_M5: begin
				if (mode == itc_pkg::ITC_M5 && !wave_out) begin
					next_out = 1'b1;
				end
				if (trig && have_count) begin
					next_ce = cr;
					next_run = 1'b1;
					if (mode == itc_pkg::ITC_M1) begin
						next_out = 1'b0;
					end
				end else if (running) begin
					next_ce = dec;
					if (at_one) begin
						next_run = 1'b0;
						next_out = (mode == itc_pkg::ITC_M1);
					end
				end
			end
			itc_pkg::ITC_M2: begin
				if (load_pending && ev.gate) begin
					next_ce = cr;
					next_pend = 1'b0;
					next_run = 1'b1;
					next_out = 1'b1;
				end else if (running && ev.gate) begin
					if (at_two) begin
						next_ce = dec;
						next_out = 1'b0;
					end else if (at_one) begin
						next_ce = cr;
						next_out = 1'b1;
					end else begin
						next_ce = dec;
					end
				end
			end
			itc_pkg::ITC_M3: begin
				if (load_pending && ev.gate) begin
					next_ce = cr_even;
					next_str = cr[0];
					next_pend = 1'b0;
					next_run = 1'b1;
					next_out = 1'b1;
				end else if (running && ev.gate) begin
					if (at_two && stretch) begin
						next_str = 1'b0;
					end else if (at_two) begin
						next_out = ~wave_out;
						next_ce = cr_even;
						next_str = cr[0] & ~wave_out;
					end else begin
						next_ce = dec2;
					end
				end
			end
			default: begin
				next_ce = ce;
			end
			endcase
		end
		if (m23 && !ev.gate && running) begin
			next_out = 1'b1;
			next_run = 1'b0;
			next_pend = have_count;
		end
		if (mode == itc_pkg::ITC_M4 && ev.gate_rise && have_count) begin
			next_pend = 1'b1;
		end
		if (lsb_part && mode == itc_pkg::ITC_M0) begin
			next_halt = 1'b1;
		end
		if (cnt_done) begin
			next_have = 1'b1;
			if (m04) begin
				next_pend = 1'b1;
				next_halt = 1'b1;
			end
			if (m23 && !running) begin
				next_pend = 1'b1;
			end
		end
		if (mode_wr) begin
			next_ce = itc_pkg::COUNT_CLEAR;
			next_out = (new_mode != itc_pkg::ITC_M0);
			next_run = 1'b0;
			next_pend = 1'b0;
			next_halt = 1'b0;
			next_have = 1'b0;
			next_trig = 1'b0;
			next_str = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ce <= itc_pkg::COUNT_CLEAR;
			wave_out <= itc_pkg::WAVE_RST;
			running <= 1'b0;
			load_pending <= 1'b0;
			halt <= 1'b0;
			have_count <= 1'b0;
			trig <= 1'b0;
			stretch <= 1'b0;
		end else begin
			ce <= next_ce;
			wave_out <= next_out;
			running <= next_run;
			load_pending <= next_pend;
			halt <= next_halt;
			have_count <= next_have;
			trig <= next_trig;
			stretch <= next_str;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= itc_pkg::ITC_M0;
			fmt <= itc_pkg::FMT_LOW;
			bcd <= 1'b0;
			cr <= itc_pkg::COUNT_CLEAR;
			cr_lo <= itc_pkg::BYTE_ZERO;
			wr_msb <= 1'b0;
		end else if (mode_wr) begin
			mode <= new_mode;
			fmt <= cw.transfer_format_field;
			bcd <= cw.bcd;
			wr_msb <= 1'b0;
		end else if (cnt_wr) begin
			case (fmt)
			itc_pkg::FMT_HIGH: cr <= {wd, itc_pkg::BYTE_ZERO};
			itc_pkg::FMT_BOTH: begin
				wr_msb <= ~wr_msb;
				if (wr_msb) begin
					cr <= {wd, cr_lo};
				end else begin
					cr_lo <= wd;
				end
			end
			default: cr <= {itc_pkg::BYTE_ZERO, wd};
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch <= itc_pkg::COUNT_CLEAR;
			latched <= 1'b0;
			rd_msb <= 1'b0;
		end else if (mode_wr) begin
			latched <= 1'b0;
			rd_msb <= 1'b0;
		end else if (latch_cmd && !latched) begin
			latch <= ce;
			latched <= 1'b1;
		end else if (rd_sel) begin
			if (fmt == itc_pkg::FMT_BOTH) begin
				rd_msb <= ~rd_msb;
			end
			if (fmt != itc_pkg::FMT_BOTH || rd_msb) begin
				latched <= 1'b0;
			end
		end
	end

	// One wait state: answer in the second access cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= itc_pkg::WORD_ZERO;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~addr_ok;
			if (psel & penable & ~pready & ~pwrite) begin
				prdata <= rd_word;
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_m1_fire;
		mode == itc_pkg::ITC_M1 && ev.tick && trig && have_count && !mode_wr;
	endsequence
	sequence s_m1_low;
		!wave_out && ce == $past(cr);
	endsequence

	a_mode0_wave_low: assert property (
		mode_wr && new_mode == itc_pkg::ITC_M0 |=> !wave_out)
		else $error("mode 0 setup did not drive wave low");
	a_gate_pause: assert property (
		mode == itc_pkg::ITC_M0 && !ev.gate && !load_pending && !cnt_wr &&
		!mode_wr |=> ce == $past(ce))
		else $error("mode 0 counted with gate low");
	a_onebyte_stop: assert property (
		cnt_done && m04 && !mode_wr |=> load_pending && halt)
		else $error("count write did not halt and queue reload");
	a_twobyte_halt: assert property (
		lsb_part && mode == itc_pkg::ITC_M0 |=> halt ##0 $stable(cr))
		else $error("low byte did not halt counting");
	a_mode1_trigger: assert property (s_m1_fire |=> s_m1_low)
		else $error("mode 1 trigger did not start low pulse");
	a_mode2_pulse: assert property (
		mode == itc_pkg::ITC_M2 && running && ev.tick && ev.gate && at_two &&
		!mode_wr |=> !wave_out ##1 (!wave_out || $past(ev.tick) ||
		!$past(ev.gate) || $past(mode_wr)))
		else $error("mode 2 pulse wrong");
	a_gate_force: assert property (
		m23 && !ev.gate && running && !mode_wr |=> wave_out && !running)
		else $error("gate low did not force wave high");
	a_square_toggle: assert property (
		mode == itc_pkg::ITC_M3 && running && ev.tick && ev.gate && at_two &&
		!stretch && !mode_wr |=> wave_out != $past(wave_out))
		else $error("square wave did not toggle");
	a_mode4_restart: assert property (
		mode == itc_pkg::ITC_M4 && ev.gate_rise && have_count && !mode_wr
		|=> load_pending)
		else $error("mode 4 gate rise did not queue reload");
	a_latch_capture: assert property (
		latch_cmd && !latched |=> latched && latch == $past(ce))
		else $error("latch command did not capture count");
	a_clear_count: assert property (
		mode_wr |=> ce == itc_pkg::COUNT_CLEAR)
		else $error("control write did not clear count");
endmodule
`default_nettype wire

// ==== tb/itc_pin_model.sv ====
// Counter clock and gate pin driver that stands at the timer's far side.
`timescale 1ns/1ps
`default_nettype none
module itc_pin_model (
	// Clock
	input wire logic pclk,
	// Pins
	output var logic cnt_clk_pin,
	output var logic gate_pin
);
	// ------------------------------------------------------------
	// Pin activity
	// ------------------------------------------------------------
	initial begin
		cnt_clk_pin = 1'b0;
		gate_pin = 1'b0;
	end

	// One counter tick, each level held four system clocks.
	task automatic tick();
		@(posedge pclk);
		cnt_clk_pin <= 1'b1;
		repeat (4) @(posedge pclk);
		cnt_clk_pin <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask

	// Sets the gate level and lets it pass the synchroniser.
	task automatic gate(input logic v);
		@(posedge pclk);
		gate_pin <= v;
		repeat (6) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

// ==== tb/itc_timer_tb.sv ====
// Self-checking bench for the interval timer channel over APB.
`timescale 1ns/1ps
`default_nettype none
module itc_timer_tb;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam logic [7:0] a_cnt = 8'h00;
	localparam logic [7:0] a_ch1 = 8'h04;
	localparam logic [7:0] a_ctl = 8'h0c;
	localparam logic [7:0] a_bad = 8'h10;
	logic pclk = 1'b0;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [itc_pkg::PADDR_W-1:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic wave_out;
	wire cnt_clk_pin;
	wire gate_pin;
	int num_errors = 0;
	int cmp_count = 0;
	int hi;
	logic [31:0] rdat;
	logic rerr;
	logic [7:0] zc [3] = '{8'h00, 8'h00, 8'h10};
	logic zb [3] = '{1'b0, 1'b1, 1'b1};
	logic [7:0] ze [3] = '{8'hff, 8'h99, 8'h09};

	always #5 pclk = ~pclk;

	itc_timer dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.cnt_clk_pin(cnt_clk_pin),
		.gate_pin(gate_pin),
		.wave_out(wave_out)
	);

	itc_pin_model pins (
		.pclk(pclk),
		.cnt_clk_pin(cnt_clk_pin),
		.gate_pin(gate_pin)
	);

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic conclude();
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp,
			input string what);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got,
				exp);
		end
	endtask

	// One APB transfer; read data and error are taken with pready.
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [7:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			num_errors++;
			conclude();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		check(rdat, {24'h000000, e}, "read data");
	endtask

	task automatic ctl(input logic [1:0] f, input logic [2:0] m,
			input logic b);
		itc_pkg::itc_cw_s c;
		c.channel_pick_field = itc_pkg::CH_OWN;
		c.transfer_format_field = f;
		c.waveform_select_field = m;
		c.bcd = b;
		wr(a_ctl, c);
	endtask

	task automatic wv(input logic e);
		repeat (3) @(posedge pclk);
		check({31'h0, wave_out}, {31'h0, e}, "wave level");
	endtask

	// Ticks n times and checks the wave after each tick, first in bit 0.
	task automatic seq(input int n, input logic [7:0] e);
		for (int i = 0; i < n; i++) begin
			pins.tick();
			check({31'h0, wave_out}, {31'h0, e[i]}, "wave step");
		end
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, a_bad, 8'h00);
		check({31'h0, rerr}, 32'h1, "unmapped error");
		check(rdat, 32'h0, "unmapped data");
		rd(a_ch1, 8'h00);
		ctl(itc_pkg::FMT_LOW, 3'h0, 1'b0);
		wv(1'b0);
		pins.gate(1'b1);
		wr(a_cnt, 8'h03);
		seq(2, 8'h00);
		pins.gate(1'b0);
		seq(3, 8'h00);
		rd(a_cnt, 8'h02);
		pins.gate(1'b1);
		seq(3, 8'h06);
		ctl(itc_pkg::FMT_LOW, 3'h0, 1'b0);
		wr(a_cnt, 8'h05);
		seq(2, 8'h00);
		wr(a_cnt, 8'h02);
		seq(3, 8'h04);
		ctl(itc_pkg::FMT_BOTH, 3'h0, 1'b0);
		wr(a_cnt, 8'h02);
		wr(a_cnt, 8'h00);
		seq(2, 8'h00);
		wr(a_cnt, 8'h03);
		seq(3, 8'h00);
		rd(a_cnt, 8'h01);
		rd(a_cnt, 8'h00);
		wr(a_cnt, 8'h00);
		seq(4, 8'h08);
		ctl(itc_pkg::FMT_LOW, 3'h1, 1'b0);
		wv(1'b1);
		wr(a_cnt, 8'h02);
		pins.gate(1'b0);
		seq(2, 8'h03);
		pins.gate(1'b1);
		seq(1, 8'h00);
		pins.gate(1'b0);
		seq(2, 8'h02);
		ctl(itc_pkg::FMT_LOW, 3'h6, 1'b0);
		wv(1'b1);
		apb(1'b0, a_ctl, 8'h00);
		check({29'h0, rdat[3:1]}, 32'h2, "mode field");
		pins.gate(1'b1);
		wr(a_cnt, 8'h03);
		seq(7, 8'h5b);
		wr(a_cnt, 8'h04);
		seq(6, 8'h1d);
		pins.gate(1'b0);
		wv(1'b1);
		seq(2, 8'h03);
		pins.gate(1'b1);
		seq(4, 8'h07);
		for (int n = 2; n < 6; n++) begin
			ctl(itc_pkg::FMT_LOW, 3'h3, 1'b0);
			wr(a_cnt, 8'(n));
			pins.tick();
			hi = 0;
			for (int i = 0; i < 2 * n; i++) begin
				pins.tick();
				if (wave_out === 1'b1)
					hi++;
			end
			check(32'(hi), 32'(2 * ((n + 1) / 2)), "square highs");
		end
		ctl(itc_pkg::FMT_LOW, 3'h7, 1'b0);
		wr(a_cnt, 8'h04);
		seq(2, 8'h03);
		wr(a_cnt, 8'h06);
		seq(5, 8'h18);
		pins.gate(1'b0);
		rd(a_cnt, 8'h04);
		pins.gate(1'b1);
		for (int m = 4; m < 6; m++) begin
			ctl(itc_pkg::FMT_LOW, 3'(m), 1'b0);
			wv(1'b1);
			wr(a_cnt, 8'h02);
			if (m == 5) begin
				pins.gate(1'b0);
				pins.gate(1'b1);
			end
			seq(5, 8'h1b);
		end
		ctl(itc_pkg::FMT_LOW, 3'h4, 1'b0);
		wr(a_cnt, 8'h03);
		seq(2, 8'h03);
		pins.gate(1'b0);
		seq(2, 8'h03);
		pins.gate(1'b1);
		seq(4, 8'h07);
		for (int k = 0; k < 3; k++) begin
			ctl(itc_pkg::FMT_LOW, 3'h0, zb[k]);
			wr(a_cnt, zc[k]);
			seq(2, 8'h00);
			pins.gate(1'b0);
			rd(a_cnt, ze[k]);
			pins.gate(1'b1);
		end
		ctl(itc_pkg::FMT_LOW, 3'h0, 1'b0);
		wr(a_cnt, 8'h09);
		seq(2, 8'h00);
		ctl(itc_pkg::FMT_LATCH, 3'h0, 1'b0);
		seq(2, 8'h00);
		rd(a_cnt, 8'h08);
		pins.gate(1'b0);
		rd(a_cnt, 8'h06);
		ctl(itc_pkg::FMT_HIGH, 3'h0, 1'b0);
		wr(a_cnt, 8'h01);
		pins.tick();
		rd(a_cnt, 8'h01);
		conclude();
	end
endmodule
`default_nettype wire
